// >>> logic/tpd_timer.sv
/*
 * tpd_timer: 16-bit up timer with single PWM, dual PWM with deadband,
 * and capture modes, behind an AXI4-Lite register slave.
 * Assumes the timer input pin is asynchronous and that software stops
 * the timer before reconfiguring it.
 */
// Behaviour
// [RULE1] Count from prescaled system clock, never pins.
// [RULE2] Start count only first period, then 0001H.
// [RULE3] Software keeps reload above PWM match.
// [RULE4] Period equals reload times prescale.
// [RULE5] First period is reload minus start, prescaled.
// [RULE6] High time follows polarity bit formula.
// [RULE7] Dual PWM toggles output at match.
// [RULE8] Reload: interrupt, restart at 0001H, continue.
// [RULE9] Polarity sets start level, match inverts it.
// [RULE10] Dual PWM drives inverted second pin.
// [RULE11] Rising edges delayed by 0-128 deadband.
// [RULE12] Software keeps deadband below both phases.
// [RULE13] Software writes mode extension bit too.
// [RULE14] Dual PWM turns input pin into output.
// [RULE15] Capture copies count on chosen edge.
// [RULE16] Capture: interrupt, set flag, keep counting.
// [RULE17] Capture reload: interrupt, clear flag, continue.
// [RULE18] Interrupt source selectable: both, capture, reload.
// [RULE19] Software clears match before capture starts.
// [RULE20] Software disables timer before reconfiguring.
// [RULE21] Capture value minus start gives elapsed ticks.
// [RULE22] Count every prescale period; hold when disabled.
`timescale 1ns/1ps
`default_nettype none
module tpd_timer
	import tpd_pkg::*;
(
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write address
	input  wire logic [TPD_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read
	input  wire logic [TPD_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// timer pins
	input  wire logic                  tin_i,
	output logic                       tout_o,
	output logic                       tcomp_o,
	output logic                       tcomp_oen_n,
	// interrupt request pulse
	output logic                       timer_irq
);
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction : strb_merge

	////////////////////////////////////////////////////////////////
	// register state
	logic [7:0]            ctrl_r;
	logic [2:0]            ctrl2_r;
	logic [15:0]           count_r;
	logic [15:0]           match_r;
	logic [15:0]           reload_r;
	logic [7:0]            dbnd_r;
	logic                  capf_r;
	logic                  pwm_r;
	logic                  irq_r;
	logic                  tin_s1, tin_s2, tin_s3;
	// bus state
	logic [TPD_ADDR_W-1:0] awaddr_r;
	logic [31:0]           wdata_r;
	logic [3:0]            wstrb_r;

	////////////////////////////////////////////////////////////////
	// field decode
	wire        en_w    = ctrl_r[TPD_CTRL_EN];
	wire [1:0]  mfld_w  = ctrl_r[TPD_CTRL_MODE +: 2];
	wire        pol_w   = ctrl_r[TPD_CTRL_POL];
	wire [2:0]  pre_w   = ctrl_r[TPD_CTRL_PRE +: 3];
	wire        ext_w   = ctrl2_r[TPD_CTRL2_EXT];
	wire [1:0]  isel_w  = ctrl2_r[TPD_CTRL2_ISEL +: 2];
	tpd_mode_t  mode_w;
	always_comb begin
		unique case ({ext_w, mfld_w})
			{1'b0, TPD_MODE_PWM}:  mode_w = TPD_PWM1;
			{1'b1, TPD_MODE_PWM}:  mode_w = TPD_PWM2; // RULE13
			{1'b0, TPD_MODE_CAPT}: mode_w = TPD_CAPT;
			default:               mode_w = TPD_IDLE;
		endcase
	end
	wire        is_pwm_w  = (mode_w == TPD_PWM1) || (mode_w == TPD_PWM2);
	wire        is_capt_w = (mode_w == TPD_CAPT);
	wire        run_w     = en_w && (mode_w != TPD_IDLE);

	////////////////////////////////////////////////////////////////
	// bus decode
	wire        do_wr_w   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire [31:0] wmrg_w;
	wire        wr_ctrl_w  = do_wr_w && awaddr_r == TPD_OFF_CTRL;
	wire        wr_ctrl2_w = do_wr_w && awaddr_r == TPD_OFF_CTRL2;
	wire        wr_count_w = do_wr_w && awaddr_r == TPD_OFF_COUNT;
	wire        wr_match_w = do_wr_w && awaddr_r == TPD_OFF_MATCH;
	wire        wr_reld_w  = do_wr_w && awaddr_r == TPD_OFF_RELD;
	wire        wr_dbnd_w  = do_wr_w && awaddr_r == TPD_OFF_DBND;
	wire        wr_hit_w   = wr_ctrl_w || wr_ctrl2_w || wr_count_w || wr_match_w || wr_reld_w || wr_dbnd_w;
	wire [31:0] wold_w =
		(awaddr_r == TPD_OFF_CTRL)  ? {24'h000000, ctrl_r} :
		(awaddr_r == TPD_OFF_CTRL2) ? {29'h00000000, ctrl2_r} :
		(awaddr_r == TPD_OFF_COUNT) ? {16'h0000, count_r} :
		(awaddr_r == TPD_OFF_MATCH) ? {16'h0000, match_r} :
		(awaddr_r == TPD_OFF_RELD)  ? {16'h0000, reload_r} :
		{24'h000000, dbnd_r};
	assign wmrg_w = strb_merge(wold_w, wdata_r, wstrb_r);
	// deadband beyond the documented range is clamped, not wrapped
	wire [7:0]  db_wr_w = (wmrg_w[7:0] > TPD_DB_MAX) ? TPD_DB_MAX : wmrg_w[7:0]; // RULE11

	wire        rd_hit_w = s_axi_araddr == TPD_OFF_CTRL  || s_axi_araddr == TPD_OFF_CTRL2 ||
		s_axi_araddr == TPD_OFF_COUNT || s_axi_araddr == TPD_OFF_MATCH ||
		s_axi_araddr == TPD_OFF_RELD  || s_axi_araddr == TPD_OFF_DBND;
	wire [31:0] rd_mux_w =
		(s_axi_araddr == TPD_OFF_CTRL)  ? {24'h000000, ctrl_r} :
		(s_axi_araddr == TPD_OFF_CTRL2) ? {24'h000000, capf_r, 4'h0, ctrl2_r} :
		(s_axi_araddr == TPD_OFF_COUNT) ? {16'h0000, count_r} :
		(s_axi_araddr == TPD_OFF_MATCH) ? {16'h0000, match_r} :
		(s_axi_araddr == TPD_OFF_RELD)  ? {16'h0000, reload_r} :
		(s_axi_araddr == TPD_OFF_DBND)  ? {24'h000000, dbnd_r} : 32'h00000000;

	////////////////////////////////////////////////////////////////
	// axi4-lite handshakes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= TPD_RESP_OK;
			awaddr_r      <= '0;
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr_w) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit_w ? TPD_RESP_OK : TPD_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= TPD_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux_w;
			s_axi_rresp   <= rd_hit_w ? TPD_RESP_OK : TPD_RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// prescaler and input synchroniser
	logic tick_w;
	tpd_prescale u_pre (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (run_w), // RULE1
		.pre     (pre_w),
		.tick    (tick_w)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tin_s1 <= 1'b0;
			tin_s2 <= 1'b0;
			tin_s3 <= 1'b0;
		end else begin
			tin_s1 <= tin_i;
			tin_s2 <= tin_s1;
			tin_s3 <= tin_s2;
		end
	end
	// polarity 1 captures on rising, 0 on falling
	wire edge_w  = pol_w ? (tin_s2 && !tin_s3) : (!tin_s2 && tin_s3);
	wire cap_w   = en_w && is_capt_w && edge_w; // RULE15
	wire at_rl_w = (count_r == reload_r);
	wire wrap_w  = tick_w && run_w && at_rl_w;

	////////////////////////////////////////////////////////////////
	// counter, match and control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r   <= 8'h00;
			ctrl2_r  <= 3'h0;
			reload_r <= TPD_RELD_RST;
			dbnd_r   <= 8'h00;
			count_r  <= TPD_COUNT_RST;
			match_r  <= TPD_MATCH_RST;
		end else begin
			if (wr_ctrl_w)  ctrl_r   <= wmrg_w[7:0];
			if (wr_ctrl2_w) ctrl2_r  <= wmrg_w[2:0];
			if (wr_reld_w)  reload_r <= wmrg_w[15:0];
			if (wr_dbnd_w)  dbnd_r   <= db_wr_w;
			if (wr_count_w) begin
				count_r <= wmrg_w[15:0]; // RULE5 RULE21
			end else if (wrap_w) begin
				count_r <= TPD_RESTART; // RULE2 RULE8 RULE17
			end else if (tick_w && run_w) begin
				count_r <= 16'(count_r + 16'h0001); // RULE22 RULE16
			end
			// a capture in the same cycle as a software write wins
			if (cap_w) begin
				match_r <= count_r; // RULE15 RULE21
			end else if (wr_match_w) begin
				match_r <= wmrg_w[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// flag, pwm level and interrupt
	wire irq_nxt_w = (is_pwm_w && wrap_w) || // RULE8
		(is_capt_w && cap_w && isel_w != TPD_ISEL_RELD) || // RULE16 RULE18
		(is_capt_w && wrap_w && isel_w != TPD_ISEL_CAPT); // RULE17 RULE18
	// enabling write sets the start level at once, not a period late
	wire pol_nxt_w = wr_ctrl_w ? wmrg_w[TPD_CTRL_POL] : pol_w; // RULE9

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capf_r <= 1'b0;
			pwm_r  <= 1'b0;
			irq_r  <= 1'b0;
		end else begin
			if (cap_w) begin
				capf_r <= 1'b1; // RULE16
			end else if (is_capt_w && wrap_w) begin
				capf_r <= 1'b0; // RULE17
			end
			if (!run_w || !is_pwm_w) begin
				pwm_r <= pol_nxt_w; // RULE9
			end else if (wrap_w) begin
				pwm_r <= pol_w; // RULE9
			end else if (tick_w && count_r == match_r) begin
				pwm_r <= !pol_w; // RULE6 RULE7
			end
			irq_r <= irq_nxt_w;
		end
	end

	////////////////////////////////////////////////////////////////
	// output pins
	logic db_a_w, db_b_w;
	tpd_deadband u_db (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (pwm_r),
		.db      (dbnd_r),
		.out_a   (db_a_w),
		.out_b   (db_b_w)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tout_o      <= 1'b0;
			tcomp_o     <= 1'b0;
			tcomp_oen_n <= 1'b1;
			timer_irq   <= 1'b0;
		end else begin
			tout_o      <= (mode_w == TPD_PWM2) ? db_a_w : pwm_r; // RULE11
			tcomp_o     <= (mode_w == TPD_PWM2) && db_b_w; // RULE10
			tcomp_oen_n <= (mode_w != TPD_PWM2); // RULE14
			timer_irq   <= irq_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	count_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE22
		!run_w && !wr_count_w && $stable(ctrl_r) |=> $stable(count_r)) else $error("count moved while stopped");
	restart_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
		wrap_w && !wr_count_w |=> count_r == TPD_RESTART) else $error("no restart at 0001");
	pwm_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
		is_pwm_w && wrap_w |-> ##2 timer_irq) else $error("reload interrupt missing");
	match_level_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
		mode_w == TPD_PWM1 && tick_w && !at_rl_w && count_r == match_r && $stable(ctrl_r)[*1]
		|-> ##2 tout_o == !$past(pol_w, 2)) else $error("match did not invert output");
	pin_dir_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
		mode_w == TPD_PWM2 |=> !tcomp_oen_n) else $error("pin not turned to output");
	capture_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
		cap_w |=> match_r == $past(count_r)) else $error("capture value wrong");
	capflag_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
		cap_w && isel_w != TPD_ISEL_RELD |=> capf_r ##1 timer_irq) else $error("capture flag or irq missing");
	capclr_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
		is_capt_w && wrap_w && !cap_w |=> !capf_r) else $error("flag not cleared at reload");
	isel_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
		is_capt_w && isel_w == TPD_ISEL_RELD && !wrap_w |-> ##2 !timer_irq) else $error("masked source fired");

	pwm_wrap_c: cover property (@(posedge aclk) disable iff (!aresetn) is_pwm_w && wrap_w);
	dual_c:     cover property (@(posedge aclk) disable iff (!aresetn) tcomp_o && !tcomp_oen_n);
	capt_c:     cover property (@(posedge aclk) disable iff (!aresetn) cap_w);
endmodule : tpd_timer
`default_nettype wire

// >>> logic/tpd_pkg.sv
/*
 * tpd_pkg: register map, field positions, reset values and mode
 * encodings of the dual-output PWM / capture timer.
 * Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
 */
package tpd_pkg;
	localparam int        TPD_ADDR_W   = 8;
	// register byte offsets
	localparam logic [7:0] TPD_OFF_CTRL  = 8'h00;
	localparam logic [7:0] TPD_OFF_CTRL2 = 8'h04;
	localparam logic [7:0] TPD_OFF_COUNT = 8'h08;
	localparam logic [7:0] TPD_OFF_MATCH = 8'h0C;
	localparam logic [7:0] TPD_OFF_RELD  = 8'h10;
	localparam logic [7:0] TPD_OFF_DBND  = 8'h14;
	// control field positions
	localparam int TPD_CTRL_EN    = 0;
	localparam int TPD_CTRL_MODE  = 1;
	localparam int TPD_CTRL_POL   = 3;
	localparam int TPD_CTRL_PRE   = 4;
	localparam int TPD_CTRL2_EXT  = 0;
	localparam int TPD_CTRL2_ISEL = 1;
	localparam int TPD_CTRL2_CAPF = 7;
	// mode field and interrupt source codes
	localparam logic [1:0] TPD_MODE_PWM   = 2'h1;
	localparam logic [1:0] TPD_MODE_CAPT  = 2'h2;
	localparam logic [1:0] TPD_ISEL_CAPT  = 2'h1;
	localparam logic [1:0] TPD_ISEL_RELD  = 2'h2;
	// reset values, counting constants and bus response codes
	localparam logic [15:0] TPD_COUNT_RST = 16'h0001;
	localparam logic [15:0] TPD_RESTART   = 16'h0001;
	localparam logic [15:0] TPD_RELD_RST  = 16'hFFFF;
	localparam logic [15:0] TPD_MATCH_RST = 16'h0000;
	localparam logic [7:0]  TPD_DB_MAX    = 8'h80;
	localparam logic [1:0]  TPD_RESP_OK   = 2'h0;
	localparam logic [1:0]  TPD_RESP_ERR  = 2'h2;

	typedef enum logic [1:0] {
		TPD_IDLE, TPD_PWM1, TPD_PWM2, TPD_CAPT
	} tpd_mode_t;
endpackage : tpd_pkg

// >>> logic/tpd_prescale.sv
/*
 * tpd_prescale: divides the system clock by 2^pre, one-cycle tick.
 * Assumes run is low whenever the timer is disabled.
 */
`timescale 1ns/1ps
`default_nettype none
module tpd_prescale (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// control
	input  wire logic       run,
	input  wire logic [2:0] pre,
	// tick out
	output logic            tick
);
	logic [6:0] cnt_r;
	wire  [6:0] term_w = 7'((8'h01 << pre) - 8'h01);
	wire        last_w = (cnt_r == term_w);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 7'h00;
			tick  <= 1'b0;
		end else begin
			cnt_r <= (run && !last_w) ? 7'(cnt_r + 7'h01) : 7'h00; // RULE1
			tick  <= run && last_w; // RULE4
		end
	end

	////////////////////////////////////////////////////////////////
	tick_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
		tick && pre != 3'h0 |=> !tick) else $error("prescale tick too soon");
endmodule : tpd_prescale
`default_nettype wire

// >>> logic/tpd_deadband.sv
/*
 * tpd_deadband: splits a PWM level into two complementary outputs whose
 * rising edges are held back by db cycles. Falling edges pass at once.
 * Assumes db is at most 128 and stable while the timer runs.
 */
`timescale 1ns/1ps
`default_nettype none
module tpd_deadband (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// pwm in
	input  wire logic       level,
	input  wire logic [7:0] db,
	// outputs
	output logic            out_a,
	output logic            out_b
);
	logic       lvl_r;
	logic [7:0] cnt_r;
	wire        chg_w   = (level != lvl_r);
	wire  [7:0] cnt_nxt = chg_w ? 8'h00 : ((cnt_r == 8'hFF) ? cnt_r : 8'(cnt_r + 8'h01));
	wire        ok_w    = (cnt_nxt >= db);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_r <= 1'b0;
			cnt_r <= 8'hFF;
			out_a <= 1'b0;
			out_b <= 1'b0;
		end else begin
			lvl_r <= level;
			cnt_r <= cnt_nxt;
			out_a <= level && ok_w; // RULE11
			out_b <= !level && ok_w; // RULE10 RULE11
		end
	end

	////////////////////////////////////////////////////////////////
	no_overlap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
		!(out_a && out_b)) else $error("both outputs active");
	rise_held_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
		chg_w && db != 8'h00 |=> !out_a && !out_b) else $error("deadband skipped");
endmodule : tpd_deadband
`default_nettype wire

// >>> sim/tpd_pin_model.sv
/* tpd_pin_model: pad of the shared timer input / complementary output pin.
 * Assumes the bench sets the level that the outside world puts on the pad. */
`timescale 1ns/1ps
`default_nettype none
module tpd_pin_model (
	// device side
	input  wire logic tcomp_o,
	input  wire logic tcomp_oen_n,
	// outside world
	input  wire logic ext,
	output logic      tin_i
);
	// the device wins the pad only while it drives it
	assign tin_i = tcomp_oen_n ? ext : tcomp_o;
endmodule : tpd_pin_model
`default_nettype wire

// >>> sim/tpd_timer_test.sv
/* tpd_timer_test: self-checking bench of the timer, with an integer model.
 * Assumes the package offsets and the hand-over latencies of the bus. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module tpd_timer_test;
	import tpd_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, tin_i, lvl, noisy;
	logic        tout_o, tcomp_o, tcomp_oen_n, timer_irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          n_fail, comparisons, cyc, hi_a, hi_b, ovl;
	int          tq[$];
	int          mreg[6] = '{0, 0, 1, 0, 'hFFFF, 0};
	int          msk[6]  = '{'h7F, 'h7, 'hFFFF, 'hFFFF, 'hFFFF, 'hFF};
	bit [31:0]   seed    = 32'h7AF16E5C;

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	tpd_timer u_tpd_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tin_i(tin_i),
		.tout_o(tout_o), .tcomp_o(tcomp_o), .tcomp_oen_n(tcomp_oen_n), .timer_irq(timer_irq));
	tpd_pin_model u_tpd_pin_model (.tcomp_o(tcomp_o), .tcomp_oen_n(tcomp_oen_n), .ext(lvl), .tin_i(tin_i));

	function automatic int rnd(input int lo, input int hi);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return lo + int'(seed % (hi - lo + 1));
	endfunction : rnd

	task automatic finish_test;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////
	// irq times, phase counts in the third period, pin noise, timeout
	always @(posedge aclk) begin
		cyc++;
		if (timer_irq === 1'b1)
			tq.push_back(cyc);
		if (tq.size() == 2) begin
			hi_a += tout_o;
			hi_b += tcomp_o;
			ovl += tout_o & tcomp_o;
		end
		if (noisy)
			lvl <= rnd(0, 1);
		if (cyc > 40000) begin
			n_fail++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input int v);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		r = bresp;
		bready <= 1'b0;
		if (i == 50)
			n_fail++;
		`CHK(r, a < 8'h18 ? TPD_RESP_OK : TPD_RESP_ERR)
		if (a < 8'h18) begin
			v &= msk[a >> 2];
			mreg[a >> 2] = (a == TPD_OFF_DBND && v > 128) ? 128 : v;
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input bit cmp);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (i == 50)
			n_fail++;
		if (cmp) begin
			`CHK(r, a < 8'h18 ? TPD_RESP_OK : TPD_RESP_ERR)
			`CHK(a == TPD_OFF_CTRL2 ? d & 32'h7F : d, a < 8'h18 ? mreg[a >> 2] : 0)
		end
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	task automatic pwm(input int pol, input int pre, input int m, input int rl, input int dual, input int db,
		input int s);
		int f, hi, t0;
		f = 1 << pre;
		wr(TPD_OFF_CTRL, 0);
		wr(TPD_OFF_CTRL2, dual);
		wr(TPD_OFF_MATCH, m);
		wr(TPD_OFF_RELD, rl);
		wr(TPD_OFF_DBND, db);
		wr(TPD_OFF_COUNT, s);
		tq.delete();
		hi_a = 0;
		hi_b = 0;
		ovl = 0;
		noisy <= (dual == 0);
		wr(TPD_OFF_CTRL, 1 | TPD_MODE_PWM << 1 | pol << 3 | pre << 4);
		t0 = cyc;
		@(posedge aclk);
		if (!dual)
			`CHK(tout_o, pol)
		while (tq.size() < 3)
			@(posedge aclk);
		noisy <= 1'b0;
		hi = pol ? m * f : (rl - m) * f;
		`CHK(tq[0] - t0 - (rl - s) * f inside {[-2:2 * f + 6]}, 1'b1)
		`CHK(tq[1] - tq[0], rl * f)
		`CHK(tq[2] - tq[1], rl * f)
		if (dual) begin
			`CHK(hi_a, hi - db)
			`CHK(hi_b, rl * f - hi - db)
			`CHK(ovl, 0)
		end else begin
			`CHK(hi_a, hi)
		end
		`CHK(tcomp_oen_n, dual == 0)
		wr(TPD_OFF_CTRL, 0);
		$display("pwm test done pol=%0d pre=%0d dual=%0d db=%0d", pol, pre, dual, db);
	endtask : pwm

	task automatic cap(input int pol, input int isel);
		int s, w, t0, c;
		s = rnd(1, 20);
		w = rnd(60, 120);
		lvl <= pol;
		wr(TPD_OFF_CTRL, 0);
		wr(TPD_OFF_CTRL2, isel << 1);
		wr(TPD_OFF_MATCH, 0);
		wr(TPD_OFF_RELD, 400);
		wr(TPD_OFF_COUNT, s);
		tq.delete();
		wr(TPD_OFF_CTRL, 1 | TPD_MODE_CAPT << 1 | pol << 3);
		t0 = cyc;
		repeat (w) @(posedge aclk);
		// opposite edge first: must not capture
		lvl <= !pol;
		repeat (w) @(posedge aclk);
		lvl <= pol;
		repeat (20) @(posedge aclk);
		rd(TPD_OFF_MATCH, 0);
		c = d;
		`CHK(c - s - 2 * w inside {[-2:8]}, 1'b1)
		`CHK(tq.size(), isel != 2)
		rd(TPD_OFF_CTRL2, 0);
		`CHK(d[7], 1'b1)
		rd(TPD_OFF_COUNT, 0);
		`CHK(d > c, 1'b1)
		while (cyc - t0 < 430)
			@(posedge aclk);
		`CHK(tq.size(), (isel != 2) + (isel != 1))
		rd(TPD_OFF_CTRL2, 0);
		`CHK(d[7], 1'b0)
		wr(TPD_OFF_CTRL, 0);
		rd(TPD_OFF_COUNT, 0);
		c = d;
		repeat (10) @(posedge aclk);
		rd(TPD_OFF_COUNT, 0);
		`CHK(d, c)
		$display("capture test done pol=%0d isel=%0d", pol, isel);
	endtask : cap

	////////////////////////////////////////////////////////////////////////
	initial begin
		int rl, m, f, lim;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, lvl, noisy} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a <= 8'h18; a += 4)
			rd(a, 1);
		wr(TPD_OFF_DBND, 200);
		rd(TPD_OFF_DBND, 1);
		wr(8'h18, 5);
		wr(TPD_OFF_CTRL2, 32'hFF);
		rd(TPD_OFF_CTRL2, 1);
		// reserved mode code with enable set: counter must stay put
		wr(TPD_OFF_CTRL, 7);
		rd(TPD_OFF_COUNT, 1);
		repeat (20) @(posedge aclk);
		rd(TPD_OFF_COUNT, 1);
		wr(TPD_OFF_CTRL, 0);
		$display("register test done");
		for (int k = 0; k < 8; k++)
			cap(k & 1, k >> 1);
		for (int k = 0; k < 12; k++) begin
			f = 1 << (k % 3);
			rl = rnd(10, 40);
			m = rnd(3, rl - 3);
			lim = (m < rl - m ? m : rl - m) * f - 1;
			pwm(k / 6, k % 3, m, rl, k & 1, rnd(0, lim > 128 ? 128 : lim), rnd(1, rl - 1));
		end
		pwm(0, 2, 40, 80, 1, 128, 1);
		finish_test();
	end
endmodule : tpd_timer_test
`default_nettype wire
